// ### inc/spdsel_map.vh
// Register offsets, field layouts, reset values, limits and scale constants of the speed command selector.
// Assumes byte addressing on a plain register port with 32-bit data.
`ifndef SPDSEL_MAP_VH
`define SPDSEL_MAP_VH

`define SPDSEL_ADDR_W              12
`define SPDSEL_OFF_GAIN            12'h0200
`define SPDSEL_OFF_FFWD            12'h0204
`define SPDSEL_OFF_PRESET1         12'h0300
`define SPDSEL_OFF_PRESET2         12'h0304
`define SPDSEL_OFF_PRESET3         12'h0308
`define SPDSEL_OFF_MAXSPD          12'h030C
`define SPDSEL_OFF_CTRL            12'h0310
`define SPDSEL_OFF_STATUS          12'h0314
`define SPDSEL_OFF_CMD             12'h0318

`define SPDSEL_GAIN_RST            16'h0023
`define SPDSEL_GAIN_MAX            16'h07FF
`define SPDSEL_FFWD_RST            16'h0032
`define SPDSEL_FFWD_MAX            16'h0064
`define SPDSEL_PRESET_MAX          32'h0000_C350
`define SPDSEL_PRESET_MIN          32'hFFFF_3CB0
`define SPDSEL_MAXSPD_RST          16'h0BB8
`define SPDSEL_MAXSPD_MAX          16'h2710
`define SPDSEL_BW_MAX              4'h9
`define SPDSEL_BW_RST              4'h4
`define SPDSEL_VOLT_FULL           32'h0000_2710

`define SPDSEL_CTRL_ZERO_BIT       0
`define SPDSEL_CTRL_TORQUE_BIT     1
`define SPDSEL_CTRL_AUTO_BIT       2
`define SPDSEL_CTRL_BW_LSB         4
`define SPDSEL_CTRL_BW_MSB         7

`endif

// ### verilog/spdsel_sync.v
// Two-stage register for one synchronous select input, with a change pulse.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/10ps
module spdsel_sync (
   input  wire sys_clk,
   input  wire rst_n,
   input  wire clk_en,
   input  wire din,
   output reg  dout_r,
   output reg  chg_r
);
   reg stage_r;

   // The first stage feeds the second and the change pulse; a change is seen between stages one and two.
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage_r <= 1'b0;
         dout_r  <= 1'b0;
         chg_r   <= 1'b0;
      end else if (clk_en) begin
         stage_r <= din;
         dout_r  <= stage_r;
         chg_r   <= dout_r ^ stage_r;
      end
   end
endmodule

// ### verilog/spdsel_top.v
// Speed command selector: select inputs, presets, analog scaling and loop gain registers.
// Assumes a plain register port master and synchronous select inputs on sys_clk.
`timescale 1ns/10ps
`include "spdsel_map.vh"
// Contract
// R1: Both selects low in analog mode: command is scaled analog voltage, +/-10 V.
// R2: Both selects low in zero-reference mode: command is zero, analog ignored.
// R3: Select 0,1 picks preset one, 1,0 preset two, 1,1 preset three.
// R4: Presets are signed, clamped to -50000..+50000, unit 0.1 r/min.
// R5: A new preset becomes active only after a select input changes.
// R6: Select input reads 0 when contact off, 1 when on.
// R7: The selected command also drives the torque-mode speed limit; in torque mode the code loads only speed_limit_r and speed_cmd_r holds.
// R8: Position loop gain is 16 bits, 0..2047, reset 35, rad/s.
// R9: Feed-forward gain is percent 0..100, reset 50, used in position commands.
// R10: Manual tuning disables automatic gain functions; user gains used.
// R11: Auto tuning adapts gains from inertia with one of ten bandwidth levels.
// R12: Configurer keeps position bandwidth at most a quarter of speed bandwidth.
// R13: Analog speed equals voltage times max analog speed divided by ten volts.
// R14: Selects are registered; only a registered change activates a new preset.
module spdsel_top #(
   parameter CMD_W  = 32,
   parameter VOLT_W = 16
) (
   input  wire                       sys_clk,
   input  wire                       rst_n,
   input  wire                       clk_en,
   input  wire [`SPDSEL_ADDR_W-1:0]  reg_addr,
   input  wire [31:0]                reg_wdata,
   input  wire                       reg_wr,
   input  wire                       reg_rd,
   output reg  [31:0]                reg_rdata_r,
   input  wire                       speed_select_low,
   input  wire                       speed_select_high,
   input  wire signed [VOLT_W-1:0]   analog_mv,
   input  wire signed [VOLT_W-1:0]   tuned_gain,
   output reg  signed [CMD_W-1:0]    speed_cmd_r,
   output reg  signed [CMD_W-1:0]    speed_limit_r,
   output reg  [15:0]                gain_out_r,
   output reg  [15:0]                ffwd_out_r,
   output reg                        auto_tune_en_r,
   output reg  [3:0]                 bw_level_r
);
   reg  [15:0]              position_loop_gain_r;
   reg  [15:0]              position_feed_forward_gain_r;
   reg  signed [31:0]       speed_preset_one_r;
   reg  signed [31:0]       speed_preset_two_r;
   reg  signed [31:0]       speed_preset_three_r;
   reg  [15:0]              max_analog_speed_r;
   reg                      zero_ref_r;
   reg                      torque_mode_r;
   reg                      tuning_mode_select_r;
   reg  [3:0]               bw_sel_r;
   reg  signed [31:0]       preset_act_r;
   reg  [1:0]               sel_prev_r;
   reg  signed [31:0]       preset_nxt;
   reg  [31:0]              rdata_nxt;
   reg  signed [CMD_W-1:0]  cmd_nxt;
   wire                     sel_lo;
   wire                     sel_hi;
   wire [1:0]               sel;
   wire                     sel_chg;
   wire signed [47:0]       analog_prod;
   wire signed [47:0]       analog_spd;
   wire signed [31:0]       wdata_s;

   spdsel_sync u_sync_lo (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .din     (speed_select_low),
      .dout_r  (sel_lo),
      .chg_r   ()
   );

   spdsel_sync u_sync_hi (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .din     (speed_select_high),
      .dout_r  (sel_hi),
      .chg_r   ()
   );

   assign sel     = {sel_hi, sel_lo}; // [R6]
   assign sel_chg = (sel != sel_prev_r); // [R14]
   assign wdata_s = reg_wdata;

   // Analog millivolts scaled by max speed over full scale, giving r/min. [R13]
   assign analog_prod = analog_mv * $signed({1'b0, max_analog_speed_r});
   assign analog_spd  = analog_prod / $signed({16'h0000, `SPDSEL_VOLT_FULL});

   // Preset chosen by the select pattern; held register only loads on a change. [R3]
   always @* begin
      case (sel)
         2'b01:   preset_nxt = speed_preset_one_r;
         2'b10:   preset_nxt = speed_preset_two_r;
         2'b11:   preset_nxt = speed_preset_three_r;
         default: preset_nxt = preset_act_r;
      endcase
   end

   always @* begin
      if (sel == 2'b00) begin
         if (zero_ref_r) begin
            cmd_nxt = {CMD_W{1'b0}}; // [R2]
         end else begin
            cmd_nxt = analog_spd[CMD_W-1:0]; // [R1]
         end
      end else begin
         cmd_nxt = preset_act_r[CMD_W-1:0];
      end
   end

   always @* begin
      case (reg_addr)
         `SPDSEL_OFF_GAIN:    rdata_nxt = {16'h0000, position_loop_gain_r};
         `SPDSEL_OFF_FFWD:    rdata_nxt = {16'h0000, position_feed_forward_gain_r};
         `SPDSEL_OFF_PRESET1: rdata_nxt = speed_preset_one_r;
         `SPDSEL_OFF_PRESET2: rdata_nxt = speed_preset_two_r;
         `SPDSEL_OFF_PRESET3: rdata_nxt = speed_preset_three_r;
         `SPDSEL_OFF_MAXSPD:  rdata_nxt = {16'h0000, max_analog_speed_r};
         `SPDSEL_OFF_CTRL:    rdata_nxt = {24'h00_0000, bw_sel_r, 1'b0,
                                           tuning_mode_select_r, torque_mode_r, zero_ref_r};
         `SPDSEL_OFF_STATUS:  rdata_nxt = {30'h0000_0000, sel};
         `SPDSEL_OFF_CMD:     rdata_nxt = speed_cmd_r;
         default:             rdata_nxt = 32'h0000_0000;
      endcase
   end

   // A preset write is clamped to the legal signed range. [R4]
   function [31:0] clamp_preset;
      input signed [31:0] v;
      begin
         if (v > $signed(`SPDSEL_PRESET_MAX)) begin
            clamp_preset = `SPDSEL_PRESET_MAX;
         end else if (v < $signed(`SPDSEL_PRESET_MIN)) begin
            clamp_preset = `SPDSEL_PRESET_MIN;
         end else begin
            clamp_preset = v;
         end
      end
   endfunction

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         position_loop_gain_r         <= `SPDSEL_GAIN_RST;
         position_feed_forward_gain_r <= `SPDSEL_FFWD_RST;
         speed_preset_one_r           <= 32'h0000_0000;
         speed_preset_two_r           <= 32'h0000_0000;
         speed_preset_three_r         <= 32'h0000_0000;
         max_analog_speed_r           <= `SPDSEL_MAXSPD_RST;
         zero_ref_r                   <= 1'b0;
         torque_mode_r                <= 1'b0;
         tuning_mode_select_r         <= 1'b0;
         bw_sel_r                     <= `SPDSEL_BW_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `SPDSEL_OFF_GAIN: begin
               if (reg_wdata[15:0] <= `SPDSEL_GAIN_MAX) begin
                  position_loop_gain_r <= reg_wdata[15:0]; // [R8]
               end
            end
            `SPDSEL_OFF_FFWD: begin
               if (reg_wdata[15:0] <= `SPDSEL_FFWD_MAX) begin
                  position_feed_forward_gain_r <= reg_wdata[15:0]; // [R9]
               end
            end
            `SPDSEL_OFF_PRESET1: speed_preset_one_r   <= clamp_preset(wdata_s);
            `SPDSEL_OFF_PRESET2: speed_preset_two_r   <= clamp_preset(wdata_s);
            `SPDSEL_OFF_PRESET3: speed_preset_three_r <= clamp_preset(wdata_s);
            `SPDSEL_OFF_MAXSPD: begin
               if (reg_wdata[15:0] <= `SPDSEL_MAXSPD_MAX) begin
                  max_analog_speed_r <= reg_wdata[15:0];
               end
            end
            `SPDSEL_OFF_CTRL: begin
               zero_ref_r           <= reg_wdata[`SPDSEL_CTRL_ZERO_BIT];
               torque_mode_r        <= reg_wdata[`SPDSEL_CTRL_TORQUE_BIT];
               tuning_mode_select_r <= reg_wdata[`SPDSEL_CTRL_AUTO_BIT];
               if (reg_wdata[`SPDSEL_CTRL_BW_MSB:`SPDSEL_CTRL_BW_LSB] <= `SPDSEL_BW_MAX) begin
                  bw_sel_r <= reg_wdata[`SPDSEL_CTRL_BW_MSB:`SPDSEL_CTRL_BW_LSB]; // [R11]
               end
            end
            default: ;
         endcase
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_prev_r   <= 2'b00;
         preset_act_r <= 32'h0000_0000;
      end else if (clk_en) begin
         sel_prev_r <= sel;
         if (sel_chg) begin
            preset_act_r <= preset_nxt; // [R5]
         end
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r    <= 32'h0000_0000;
         speed_cmd_r    <= {CMD_W{1'b0}};
         speed_limit_r  <= {CMD_W{1'b0}};
         gain_out_r     <= `SPDSEL_GAIN_RST;
         ffwd_out_r     <= `SPDSEL_FFWD_RST;
         auto_tune_en_r <= 1'b0;
         bw_level_r     <= `SPDSEL_BW_RST;
      end else if (clk_en) begin
         reg_rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
         if (torque_mode_r) begin
            speed_limit_r <= cmd_nxt; // [R7]
         end else begin
            speed_cmd_r <= cmd_nxt;
         end
         auto_tune_en_r <= tuning_mode_select_r;
         bw_level_r     <= tuning_mode_select_r ? bw_sel_r : 4'h0;
         ffwd_out_r     <= position_feed_forward_gain_r;
         if (tuning_mode_select_r) begin
            gain_out_r <= tuned_gain; // [R11]
         end else begin
            gain_out_r <= position_loop_gain_r; // [R10]
         end
      end
   end
endmodule

// ### verif/spdsel_monitor.sv
// Concurrent checks on the speed command selector ports.
// Assumes a bind onto spdsel_top and a view of its ports only.
`timescale 1ns/10ps
`include "spdsel_map.vh"
module spdsel_monitor #(
   parameter CMD_W = 32
) (
   input wire                    sys_clk,
   input wire                    rst_n,
   input wire                    clk_en,
   input wire [11:0]             reg_addr,
   input wire [31:0]             reg_wdata,
   input wire                    reg_wr,
   input wire                    reg_rd,
   input wire [31:0]             reg_rdata_r,
   input wire                    speed_select_low,
   input wire                    speed_select_high,
   input wire signed [CMD_W-1:0] speed_cmd_r,
   input wire [15:0]             gain_out_r,
   input wire [15:0]             ffwd_out_r,
   input wire                    auto_tune_en_r,
   input wire [3:0]              bw_level_r
);
   reg  [15:0] gain_r;
   reg  [15:0] ffwd_r;
   reg  [1:0]  ctl_r;
   wire [1:0]  sel = {speed_select_high, speed_select_low};
   wire        wen = reg_wr && clk_en;
   wire        gwr = wen && reg_addr == `SPDSEL_OFF_GAIN;
   wire        fwr = wen && reg_addr == `SPDSEL_OFF_FFWD;
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_r <= 16'h0023;
         ffwd_r <= 16'h0032;
         ctl_r <= 2'h0;
      end else begin
         if (gwr && reg_wdata[15:0] <= 16'h07FF)
            gain_r <= reg_wdata[15:0];
         if (fwr && reg_wdata[15:0] <= 16'h0064)
            ffwd_r <= reg_wdata[15:0];
         if (wen && reg_addr == `SPDSEL_OFF_CTRL)
            ctl_r <= reg_wdata[1:0];
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_quiet;
      $stable(sel) && $stable(ctl_r) && sel != 2'h0 && clk_en;
   endsequence
   sequence s_zero;
      ctl_r == 2'h1 && sel == 2'h0 && clk_en;
   endsequence
   property p_hold;
      s_quiet [*7] |-> $stable(speed_cmd_r);
   endproperty
   property p_zero;
      s_zero [*7] |-> speed_cmd_r == 0;
   endproperty
   property p_rd;
      !reg_rd && clk_en |=> reg_rdata_r == 32'h0000_0000;
   endproperty
   property p_gain;
      (!auto_tune_en_r && !gwr) [*4] |-> gain_out_r == gain_r;
   endproperty
   property p_ffwd;
      !fwr [*3] |-> ffwd_out_r == ffwd_r;
   endproperty
   property p_auto;
      wen && reg_addr == `SPDSEL_OFF_CTRL && reg_wdata[2] |-> ##[1:3] auto_tune_en_r;
   endproperty
   property p_bw;
      bw_level_r <= 4'h9;
   endproperty
   property p_range;
      speed_cmd_r <= $signed(`SPDSEL_PRESET_MAX) && speed_cmd_r >= $signed(`SPDSEL_PRESET_MIN);
   endproperty
   a_hold: assert property (p_hold) else $error("command moved without select change");
   a_zero: assert property (p_zero) else $error("zero mode command not zero");
   a_rd: assert property (p_rd) else $error("read data outside read slot");
   a_gain: assert property (p_gain) else $error("manual gain wrong");
   a_ffwd: assert property (p_ffwd) else $error("feed forward gain wrong");
   a_auto: assert property (p_auto) else $error("auto tuning not enabled");
   a_bw: assert property (p_bw) else $error("bandwidth level above nine");
   a_range: assert property (p_range) else $error("speed command out of range");
endmodule
bind spdsel_top spdsel_monitor #(.CMD_W(CMD_W)) mon_u (
   .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .speed_select_low(speed_select_low), .speed_select_high(speed_select_high),
   .speed_cmd_r(speed_cmd_r), .gain_out_r(gain_out_r), .ffwd_out_r(ffwd_out_r),
   .auto_tune_en_r(auto_tune_en_r), .bw_level_r(bw_level_r));

// ### verif/spdsel_ctrl_model.sv
// Motion controller model driving the select contacts and analog reference.
// Assumes the bench requests contact states and millivolts within +/-10 V.
`timescale 1ns/10ps
module spdsel_ctrl_model (
   input  wire               sys_clk,
   input  wire [1:0]         contact_on,
   input  wire signed [15:0] req_mv,
   output reg                speed_select_low,
   output reg                speed_select_high,
   output reg  signed [15:0] analog_mv
);
   initial begin
      speed_select_low = 1'b0;
      speed_select_high = 1'b0;
      analog_mv = 16'h0000;
   end
   always @(posedge sys_clk) begin
      speed_select_low <= contact_on[0];
      speed_select_high <= contact_on[1];
      analog_mv <= req_mv;
   end
endmodule

// ### verif/tb.sv
// Self-checking bench for the speed command selector.
// Assumes the design, its map header, checker and controller model are compiled.
`timescale 1ns/10ps
`include "spdsel_map.vh"
module tb;
   reg                sys_clk, rst_n, clk_en, reg_wr, reg_rd;
   reg  [11:0]        reg_addr;
   reg  [31:0]        reg_wdata, seed;
   reg  signed [15:0] tuned_gain, req_mv;
   reg  [1:0]         contact_on;
   wire [31:0]        reg_rdata_r;
   wire               sel_lo, sel_hi, auto_tune_en_r;
   wire signed [15:0] analog_mv;
   wire signed [31:0] speed_cmd_r, speed_limit_r;
   wire [15:0]        gain_out_r, ffwd_out_r;
   wire [3:0]         bw_level_r;
   integer            bad_count, comparisons, i;
   reg  signed [31:0] p [1:3];
   reg  signed [31:0] ms;
   spdsel_ctrl_model ctl_u (.sys_clk(sys_clk), .contact_on(contact_on), .req_mv(req_mv),
      .speed_select_low(sel_lo), .speed_select_high(sel_hi), .analog_mv(analog_mv));
   spdsel_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
      .speed_select_low(sel_lo), .speed_select_high(sel_hi), .analog_mv(analog_mv),
      .tuned_gain(tuned_gain), .speed_cmd_r(speed_cmd_r), .speed_limit_r(speed_limit_r),
      .gain_out_r(gain_out_r), .ffwd_out_r(ffwd_out_r), .auto_tune_en_r(auto_tune_en_r),
      .bw_level_r(bw_level_r));
   function [31:0] clamp(input signed [31:0] v);
      clamp = v > $signed(`SPDSEL_PRESET_MAX) ? `SPDSEL_PRESET_MAX :
              v < $signed(`SPDSEL_PRESET_MIN) ? `SPDSEL_PRESET_MIN : v;
   endfunction
   function [31:0] ana(input signed [31:0] mv, input signed [31:0] top);
      ana = mv * top / $signed(`SPDSEL_VOLT_FULL);
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] e);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata_r, e);
      end
   endtask
   task hold_sel(input [1:0] s);
      begin
         @(posedge sys_clk);
         contact_on <= s;
         repeat (8) @(posedge sys_clk);
         #1;
      end
   endtask
   task final_report;
      begin
         if (bad_count == 0 && comparisons > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count = bad_count + 1;
      final_report;
   end
   initial begin
      {rst_n, reg_wr, reg_rd, contact_on} = 5'h00;
      clk_en = 1'b1;
      reg_addr = 12'h000;
      reg_wdata = 32'h0000_0000;
      tuned_gain = 16'h0000;
      req_mv = 16'h0000;
      bad_count = 0;
      comparisons = 0;
      seed = $urandom(56808);
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`SPDSEL_OFF_GAIN, 32'h0000_0023);
      rd(`SPDSEL_OFF_FFWD, 32'h0000_0032);
      rd(12'h3FC, 32'h0000_0000);
      wr(`SPDSEL_OFF_GAIN, 32'h0000_0800);
      rd(`SPDSEL_OFF_GAIN, 32'h0000_0023);
      wr(`SPDSEL_OFF_GAIN, 32'h0000_007D);
      rd(`SPDSEL_OFF_GAIN, 32'h0000_007D);
      wr(`SPDSEL_OFF_GAIN, 32'h0000_07FF);
      wr(`SPDSEL_OFF_FFWD, 32'h0000_0065);
      rd(`SPDSEL_OFF_FFWD, 32'h0000_0032);
      p[1] = 32'h0000_EA60;
      p[2] = 32'hFFFF_15A0;
      p[3] = $urandom_range(100000) - 50000;
      for (i = 1; i < 4; i = i + 1) begin
         wr(`SPDSEL_OFF_PRESET1 + 12'(4 * i - 4), p[i]);
         rd(`SPDSEL_OFF_PRESET1 + 12'(4 * i - 4), clamp(p[i]));
         hold_sel(i[1:0]);
         chk(speed_cmd_r, clamp(p[i]));
      end
      ms = clamp(p[3]);
      p[3] = $urandom_range(100000) - 50000;
      wr(`SPDSEL_OFF_PRESET3, p[3]);
      hold_sel(2'h3);
      chk(speed_cmd_r, ms);
      hold_sel(2'h1);
      hold_sel(2'h3);
      chk(speed_cmd_r, clamp(p[3]));
      wr(`SPDSEL_OFF_CTRL, 32'h0000_0002);
      hold_sel(2'h2);
      chk(speed_limit_r, clamp(p[2]));
      ms = $urandom_range(10000);
      wr(`SPDSEL_OFF_CTRL, 32'h0000_0000);
      wr(`SPDSEL_OFF_MAXSPD, ms);
      for (i = 0; i < 4; i = i + 1) begin
         req_mv <= (i == 0) ? 16'h2710 : (i == 1) ? 16'hD8F0 : 16'($urandom_range(20000) - 10000);
         hold_sel(2'h0);
         chk(speed_cmd_r, ana(req_mv, ms));
      end
      wr(`SPDSEL_OFF_CTRL, 32'h0000_0001);
      hold_sel(2'h0);
      chk(speed_cmd_r, 32'h0000_0000);
      tuned_gain <= 16'($urandom);
      wr(`SPDSEL_OFF_CTRL, 32'h0000_0074);
      wr(`SPDSEL_OFF_CTRL, 32'h0000_00A4);
      hold_sel(2'h1);
      chk({28'h0, bw_level_r}, 32'h0000_0007);
      chk({16'h0, gain_out_r}, {16'h0, tuned_gain});
      wr(`SPDSEL_OFF_CTRL, 32'h0000_0000);
      hold_sel(2'h1);
      chk({31'h0, auto_tune_en_r}, 32'h0000_0000);
      chk({16'h0, gain_out_r}, 32'h0000_07FF);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      contact_on <= 2'h2;
      repeat (8) @(posedge sys_clk);
      #1 chk(speed_cmd_r, 32'h0000_C350);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      final_report;
   end
endmodule
